// ---- src/nicd_decoder.sv ----
/*
 * Command decoder: takes 16-bit words written to the command port and
 * drives the engine controls, thresholds, filters and masks they set.
 * Assumes a register master that never issues read and write together
 * and that waits for the busy flag to fall before the next command.
 */
// Notes on behaviour
// - 16-bit command port at offset e, reads back busy and interrupt state, independent of window.
// - Top five bits are the operation, low eleven bits its parameter.
// - Byte write of upper byte at offset f is a command if low byte free.
// - Don't-care command bits are ignored by the decoder.
// - Resets and halts hold busy while running; host waits for zero.
// - Whole, receive and transmit reset ops carry a keep mask.
// - Stall group nibble 0..3 halts/resumes upload and download engines.
// - Threshold ops load reclaim, begin and early levels.
// - Transmit on/off operations ignore their parameter.
// - Packet-complete notice op marks the transmit buffer as one packet.
// - Split op divides the transmit buffer into two halves.
// - Receive on/off operations ignore their parameter.
// - Drop op discards the head packet of the receive buffer.
// - Hash op writes parameter bit 10 into hash bit selected by 5..0.
// - Address match op loads five low parameter bits.
// - Clear op clears interrupt state bits chosen by its fields.
// - Force op raises an interrupt request with no event behind it.
// - Mask ops load indication and interrupt enable masks.
// - Coax converter off and on operations.
// - Window op selects the window numbered by three low bits.
// - Counter on/off operations gate statistics counting.
// - Remaining operation codes are unused.
`timescale 1ns/1ps
`default_nettype none
module nicd_decoder
    import nicd_pkg::*;
#(
    parameter int WHOLE_CYC = WHOLE_RESET_CYC,
    parameter int HASH_BITS = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [10:0] irq_event,
    output logic operation_busy_flag,
    output nicd_reset_s reset_req,
    output logic upload_halted,
    output logic download_halted,
    output logic transmit_on,
    output logic receive_on,
    output logic counters_on,
    output logic coax_power_on,
    output logic tx_buffer_split,
    output logic packet_complete_pulse,
    output logic drop_head_pulse,
    output logic [2:0] window_sel,
    output logic [10:0] tx_begin_level,
    output logic [10:0] rx_early_level,
    output logic [7:0] tx_buffer_recover_level,
    output logic [4:0] rx_address_match_reg,
    output logic [HASH_BITS-1:0] hash_filter,
    output logic [10:0] irq_state_reg,
    output logic [10:0] irq_mask_reg,
    output logic [10:0] indication_mask_reg
);
    // The counter must hold the longest run; a shortened whole-reset
    // count must not shrink the path reset or halt counts with it.
    localparam int LONG_PATH = (PATH_RESET_CYC > HALT_CYC) ?
        PATH_RESET_CYC : HALT_CYC;
    localparam int RUN_MAX = (WHOLE_CYC > LONG_PATH) ?
        WHOLE_CYC : LONG_PATH;
    localparam int CW = $clog2(RUN_MAX + 1);
    localparam int HW = $clog2(HASH_BITS);

    typedef enum logic {ST_IDLE, ST_BUSY} nicd_state_e;

    // Operations whose low command byte carries nothing
    function automatic logic low_byte_free(input logic [4:0] op);
        case (op)
            OP_COAX_ON, OP_RX_OFF, OP_RX_ON, OP_PKT_DONE, OP_DROP_HEAD,
            OP_TX_ON, OP_TX_OFF, OP_IRQ_FORCE, OP_CNT_ON, OP_CNT_OFF,
            OP_COAX_OFF, OP_SPLIT: low_byte_free = 1'b1;
            default: low_byte_free = 1'b0;
        endcase
    endfunction

    function automatic logic [CW-1:0] run_cycles(input nicd_cmd_s c);
        logic [CW-1:0] n;
        n = '0;
        case (c.opcode)
            OP_WHOLE_RESET: n = CW'(WHOLE_CYC);
            OP_RX_RESET, OP_TX_RESET: n = CW'(PATH_RESET_CYC);
            OP_STALL: begin
                if (c.param[3:0] == UP_HALT || c.param[3:0] == DN_HALT) begin
                    n = CW'(HALT_CYC);
                end
            end
            default: n = '0;
        endcase
        return n;
    endfunction

    nicd_cmd_s cmd;
    logic cmd_fire;
    logic [CW-1:0] cmd_len;
    nicd_state_e state_q;
    logic [CW-1:0] cnt_q;

    // A byte write at the upper offset stands for a whole command only
    // when the operation ignores its low byte; others are dropped.
    always_comb begin
        cmd = reg_wdata;
        if (reg_addr == CMD_HI_OFS) begin
            cmd = {reg_wdata[7:0], 8'h00};
        end
    end

    // Commands written while busy are dropped so a reset in flight is
    // never disturbed by a host that failed to poll.
    assign cmd_fire = reg_wr && state_q == ST_IDLE &&
        (reg_addr == CMD_PORT_OFS ||
        (reg_addr == CMD_HI_OFS && low_byte_free(reg_wdata[7:3])));
    assign cmd_len = run_cycles(cmd);
    assign operation_busy_flag = state_q == ST_BUSY;
    // The counter loads len-1 so busy stands exactly len cycles.

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_fire && cmd_len != '0) begin
                        state_q <= ST_BUSY;
                        cnt_q <= cmd_len - CW'(1);
                    end
                end
                ST_BUSY: begin
                    if (cnt_q == '0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - CW'(1);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Reset requests and one-shot notices
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reset_req <= '0;
            packet_complete_pulse <= 1'b0;
            drop_head_pulse <= 1'b0;
        end else begin
            reset_req <= '0;
            packet_complete_pulse <= 1'b0;
            drop_head_pulse <= 1'b0;
            if (cmd_fire) begin
                case (cmd.opcode)
                    OP_WHOLE_RESET: begin
                        reset_req.whole <= 1'b1;
                        reset_req.keep_mask <= cmd.param & WHOLE_FIELDS;
                    end
                    OP_RX_RESET: begin
                        reset_req.rx_path <= 1'b1;
                        reset_req.keep_mask <= cmd.param & PATH_FIELDS;
                    end
                    OP_TX_RESET: begin
                        reset_req.tx_path <= 1'b1;
                        reset_req.keep_mask <= cmd.param & PATH_FIELDS;
                    end
                    OP_PKT_DONE: packet_complete_pulse <= 1'b1;
                    OP_DROP_HEAD: drop_head_pulse <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Engine and path enables
    always_ff @(posedge core_clk) begin
        if (rst) begin
            upload_halted <= 1'b0;
            download_halted <= 1'b0;
            transmit_on <= 1'b0;
            receive_on <= 1'b0;
            counters_on <= 1'b0;
            coax_power_on <= 1'b0;
            tx_buffer_split <= 1'b0;
        end else if (cmd_fire) begin
            case (cmd.opcode)
                OP_STALL: begin
                    case (cmd.param[3:0])
                        UP_HALT: upload_halted <= 1'b1;
                        UP_RESUME: upload_halted <= 1'b0;
                        DN_HALT: download_halted <= 1'b1;
                        DN_RESUME: download_halted <= 1'b0;
                        default: ;
                    endcase
                end
                OP_WHOLE_RESET: begin
                    if (!cmd.param[UPDN_KEEP_BIT]) begin
                        upload_halted <= 1'b0;
                        download_halted <= 1'b0;
                    end
                end
                OP_RX_RESET: begin
                    if (!cmd.param[NET_RX_KEEP_BIT]) begin
                        receive_on <= 1'b0;
                    end
                end
                OP_TX_ON: transmit_on <= 1'b1;
                OP_TX_OFF: transmit_on <= 1'b0;
                OP_RX_ON: receive_on <= 1'b1;
                OP_RX_OFF: receive_on <= 1'b0;
                OP_CNT_ON: counters_on <= 1'b1;
                OP_CNT_OFF: counters_on <= 1'b0;
                OP_COAX_ON: coax_power_on <= 1'b1;
                OP_COAX_OFF: coax_power_on <= 1'b0;
                OP_SPLIT: tx_buffer_split <= 1'b1;
                default: ;
            endcase
        end
    end

    // Thresholds, filters and window; parameter bits outside each
    // field are dropped here rather than trusted to be zero.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            window_sel <= '0;
            tx_begin_level <= '0;
            rx_early_level <= RX_EARLY_OFF;
            tx_buffer_recover_level <= '0;
            rx_address_match_reg <= '0;
        end else if (cmd_fire) begin
            case (cmd.opcode)
                OP_WINDOW: window_sel <= cmd.param[2:0];
                OP_TX_BEGIN: tx_begin_level <= cmd.param;
                OP_RX_EARLY: rx_early_level <= cmd.param;
                OP_RECLAIM: tx_buffer_recover_level <= cmd.param[7:0];
                OP_RX_MATCH: rx_address_match_reg <= cmd.param[4:0];
                OP_RX_RESET: begin
                    if (!cmd.param[NET_RX_KEEP_BIT]) begin
                        rx_address_match_reg <= '0;
                    end
                    if (!cmd.param[FIFO_RX_KEEP_BIT]) begin
                        rx_early_level <= RX_EARLY_OFF;
                    end
                end
                default: ;
            endcase
        end
    end

    // Only the low index bits address the filter; the rest are don't-care.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hash_filter <= '0;
        end else if (cmd_fire && cmd.opcode == OP_HASH_BIT) begin
            hash_filter[cmd.param[HW-1:0]] <= cmd.param[HASH_VAL_BIT];
        end
    end

    // Interrupt state: a new event in the clearing cycle survives.
    logic [10:0] irq_clr;
    logic [10:0] irq_set;
    logic host_clear;
    assign host_clear = cmd_fire && cmd.opcode == OP_WHOLE_RESET &&
        !cmd.param[HOST_KEEP_BIT];
    always_comb begin
        irq_clr = '0;
        irq_set = irq_event;
        if (cmd_fire && cmd.opcode == OP_IRQ_CLEAR) begin
            irq_clr = cmd.param & ACK_FIELDS;
        end
        if (host_clear) begin
            irq_clr = '1;
        end
        if (cmd_fire && cmd.opcode == OP_IRQ_FORCE) begin
            irq_set[IRQ_FORCE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_state_reg <= '0;
        end else begin
            irq_state_reg <= (irq_state_reg & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || host_clear) begin
            irq_mask_reg <= '0;
            indication_mask_reg <= '0;
        end else if (cmd_fire && cmd.opcode == OP_IRQ_MASK) begin
            irq_mask_reg <= cmd.param & EN_FIELDS;
        end else if (cmd_fire && cmd.opcode == OP_IND_MASK) begin
            indication_mask_reg <= cmd.param & EN_FIELDS;
        end
    end

    // Read side; the command port itself reads back as status.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    TX_BEGIN_OFS: reg_rdata <= {5'h00, tx_begin_level};
                    RX_EARLY_OFS: reg_rdata <= {5'h00, rx_early_level};
                    RECLAIM_OFS: reg_rdata <= {8'h00, tx_buffer_recover_level};
                    RX_MATCH_OFS: reg_rdata <= {11'h000, rx_address_match_reg};
                    IRQ_MASK_OFS: reg_rdata <= {5'h00, irq_mask_reg};
                    IND_MASK_OFS: reg_rdata <= {5'h00, indication_mask_reg};
                    CTRL_OFS: reg_rdata <= {6'h00, window_sel, tx_buffer_split,
                        coax_power_on, counters_on, download_halted,
                        upload_halted, receive_on, transmit_on};
                    CMD_PORT_OFS: reg_rdata <= {3'h0, operation_busy_flag,
                        1'b0, irq_state_reg};
                    default: reg_rdata <= '0;
                endcase
            end
        end
    end

    localparam int PATH_C = PATH_RESET_CYC;

    path_busy_len_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_RX_RESET |=> operation_busy_flag [*8])
        else $error("receive reset did not hold busy");
    path_busy_end_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_TX_RESET |-> ##(PATH_C+1) !operation_busy_flag)
        else $error("transmit reset busy did not end on time");
    halt_state_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_STALL && cmd.param[3:0] == DN_HALT
        |=> download_halted && operation_busy_flag)
        else $error("download halt not applied");
    unused_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && (cmd.opcode == 5'h14 || cmd.opcode[4:2] == 3'b111)
        |=> !operation_busy_flag && $stable(transmit_on) && $stable(window_sel))
        else $error("unused code changed state");
    window_load_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_WINDOW |=> window_sel == $past(cmd.param[2:0]))
        else $error("window not selected");
    tx_toggle_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_TX_OFF |=> !transmit_on)
        else $error("transmit not disabled");
    hash_write_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_HASH_BIT
        |=> hash_filter[$past(cmd.param[HW-1:0])] == $past(cmd.param[HASH_VAL_BIT]))
        else $error("hash bit not written");
    irq_set_wins_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_IRQ_CLEAR && irq_event[0] |=> irq_state_reg[0])
        else $error("event lost during clear");
    irq_force_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_fire && cmd.opcode == OP_IRQ_FORCE |=> irq_state_reg[IRQ_FORCE_BIT])
        else $error("forced interrupt not raised");
    busy_drop_a: assert property (@(posedge core_clk) disable iff (rst)
        operation_busy_flag && reg_wr |=> $stable(transmit_on) &&
        $stable(receive_on) && $stable(counters_on))
        else $error("command taken while busy");
endmodule // nicd_decoder
`default_nettype wire

// ---- src/nicd_pkg.sv ----
/*
 * Shared constants and carrier types for the network controller command
 * decoder: register offsets, operation codes, field masks, timing.
 * Assumes a single 250 MHz core clock.
 */
`default_nettype none
package nicd_pkg;
    // Register offsets on the 4-bit register port
    localparam logic [3:0] TX_BEGIN_OFS = 4'h0;
    localparam logic [3:0] RX_EARLY_OFS = 4'h2;
    localparam logic [3:0] RECLAIM_OFS = 4'h4;
    localparam logic [3:0] RX_MATCH_OFS = 4'h6;
    localparam logic [3:0] IRQ_MASK_OFS = 4'h8;
    localparam logic [3:0] IND_MASK_OFS = 4'ha;
    localparam logic [3:0] CTRL_OFS = 4'hc;
    localparam logic [3:0] CMD_PORT_OFS = 4'he;
    localparam logic [3:0] CMD_HI_OFS = 4'hf;

    // Operation codes (five upper command bits)
    localparam logic [4:0] OP_WHOLE_RESET = 5'h00;
    localparam logic [4:0] OP_WINDOW = 5'h01;
    localparam logic [4:0] OP_COAX_ON = 5'h02;
    localparam logic [4:0] OP_RX_OFF = 5'h03;
    localparam logic [4:0] OP_RX_ON = 5'h04;
    localparam logic [4:0] OP_RX_RESET = 5'h05;
    localparam logic [4:0] OP_STALL = 5'h06;
    localparam logic [4:0] OP_PKT_DONE = 5'h07;
    localparam logic [4:0] OP_DROP_HEAD = 5'h08;
    localparam logic [4:0] OP_TX_ON = 5'h09;
    localparam logic [4:0] OP_TX_OFF = 5'h0a;
    localparam logic [4:0] OP_TX_RESET = 5'h0b;
    localparam logic [4:0] OP_IRQ_FORCE = 5'h0c;
    localparam logic [4:0] OP_IRQ_CLEAR = 5'h0d;
    localparam logic [4:0] OP_IRQ_MASK = 5'h0e;
    localparam logic [4:0] OP_IND_MASK = 5'h0f;
    localparam logic [4:0] OP_RX_MATCH = 5'h10;
    localparam logic [4:0] OP_RX_EARLY = 5'h11;
    localparam logic [4:0] OP_TX_BEGIN = 5'h13;
    localparam logic [4:0] OP_CNT_ON = 5'h15;
    localparam logic [4:0] OP_CNT_OFF = 5'h16;
    localparam logic [4:0] OP_COAX_OFF = 5'h17;
    localparam logic [4:0] OP_RECLAIM = 5'h18;
    localparam logic [4:0] OP_HASH_BIT = 5'h19;
    localparam logic [4:0] OP_SPLIT = 5'h1b;

    // Low nibble of the stall group
    localparam logic [3:0] UP_HALT = 4'h0;
    localparam logic [3:0] UP_RESUME = 4'h1;
    localparam logic [3:0] DN_HALT = 4'h2;
    localparam logic [3:0] DN_RESUME = 4'h3;

    // Parameter field masks
    localparam logic [10:0] WHOLE_FIELDS = 11'h1bf;
    localparam logic [10:0] PATH_FIELDS = 11'h10f;
    localparam logic [10:0] ACK_FIELDS = 11'h769;
    localparam logic [10:0] EN_FIELDS = 11'h7f6;
    localparam logic [10:0] RX_EARLY_OFF = 11'h7ff;

    // Bit positions
    localparam int HASH_VAL_BIT = 10;
    localparam int IRQ_FORCE_BIT = 6;
    localparam int HOST_KEEP_BIT = 5;
    localparam int UPDN_KEEP_BIT = 8;
    localparam int NET_RX_KEEP_BIT = 2;
    localparam int FIFO_RX_KEEP_BIT = 3;
    localparam int BUSY_BIT = 12;

    // Timing
    localparam int CLK_NS = 4;
    localparam int WHOLE_RESET_NS = 1000000;
    localparam int PATH_RESET_NS = 400;
    localparam int HALT_NS = 40;
    localparam int WHOLE_RESET_CYC = (WHOLE_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int PATH_RESET_CYC = (PATH_RESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int HALT_CYC = (HALT_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [4:0] opcode;
        logic [10:0] param;
    } nicd_cmd_s;

    typedef struct packed {
        logic whole;
        logic rx_path;
        logic tx_path;
        logic [10:0] keep_mask;
    } nicd_reset_s;
endpackage
`default_nettype wire

// ---- bench/nic_command_decoder_bench.sv ----
/*
 * Self-checking bench for the command decoder: drives the register port
 * directly and checks every operation group, busy timing and refusals.
 * Assumes the decoder package is compiled first; no partner model.
 */
`timescale 1ns/1ps
`default_nettype none
module nic_command_decoder_bench;
    import nicd_pkg::*;
    // Short whole-reset count keeps the run brief
    localparam int WCYC = 20;
    logic core_clk, rst, reg_wr, reg_rd, operation_busy_flag;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [10:0] irq_event, tx_begin_level, rx_early_level;
    logic [10:0] irq_state_reg, irq_mask_reg, indication_mask_reg;
    logic upload_halted, download_halted, transmit_on, receive_on;
    logic counters_on, coax_power_on, tx_buffer_split;
    logic packet_complete_pulse, drop_head_pulse;
    logic [2:0] window_sel;
    logic [7:0] tx_buffer_recover_level;
    logic [4:0] rx_address_match_reg;
    logic [63:0] hash_filter;
    nicd_reset_s reset_req;
    int n_fail = 0;
    int cmp_count = 0;

    nicd_decoder #(.WHOLE_CYC(WCYC), .HASH_BITS(64)) u_nicd_decoder (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_event(irq_event),
        .operation_busy_flag(operation_busy_flag), .reset_req(reset_req),
        .upload_halted(upload_halted), .download_halted(download_halted),
        .transmit_on(transmit_on), .receive_on(receive_on),
        .counters_on(counters_on), .coax_power_on(coax_power_on),
        .tx_buffer_split(tx_buffer_split),
        .packet_complete_pulse(packet_complete_pulse),
        .drop_head_pulse(drop_head_pulse), .window_sel(window_sel),
        .tx_begin_level(tx_begin_level), .rx_early_level(rx_early_level),
        .tx_buffer_recover_level(tx_buffer_recover_level),
        .rx_address_match_reg(rx_address_match_reg),
        .hash_filter(hash_filter), .irq_state_reg(irq_state_reg),
        .irq_mask_reg(irq_mask_reg),
        .indication_mask_reg(indication_mask_reg));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Returns 1 ns after the taking edge, where registered results show
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic cmd(input logic [4:0] op, input logic [10:0] p);
        wr(CMD_PORT_OFS, {op, p});
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", 64'(exp), 64'(reg_rdata));
    endtask

    // Counts busy cycles from the first cycle after the command
    task automatic busy_len(input int exp);
        int n;
        n = 0;
        while (operation_busy_flag === 1'b1 && n < 1000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 1000) begin
            chk("busy timeout", 64'h0, 64'h1);
            end_of_test();
        end else begin
            chk("busy cycles", 64'(exp), 64'(n));
        end
    endtask

    task automatic t_reset_state();
        rd(RX_EARLY_OFS, 16'h07ff);
        rd(4'h1, 16'h0000);
        chk("busy", 64'h0, 64'(operation_busy_flag));
        $display("test reset_state done");
    endtask

    task automatic t_enables();
        cmd(OP_TX_ON, 11'h7ff);
        chk("transmit_on", 64'h1, 64'(transmit_on));
        cmd(OP_RX_ON, 11'h7ff);
        chk("receive_on", 64'h1, 64'(receive_on));
        cmd(OP_COAX_ON, 11'h000);
        cmd(OP_CNT_ON, 11'h5aa);
        rd(CTRL_OFS, 16'h0033);
        wr(CMD_HI_OFS, {8'h00, OP_TX_OFF, 3'h7});
        chk("transmit_on", 64'h0, 64'(transmit_on));
        wr(CMD_HI_OFS, {8'h00, OP_RX_OFF, 3'h0});
        cmd(OP_COAX_OFF, 11'h7ff);
        cmd(OP_CNT_OFF, 11'h000);
        rd(CTRL_OFS, 16'h0000);
        wr(4'h0, {OP_TX_ON, 11'h000});
        chk("transmit_on", 64'h0, 64'(transmit_on));
        $display("test enables done");
    endtask

    task automatic t_loads();
        cmd(OP_RECLAIM, 11'h0a5);
        chk("recover", 64'ha5, 64'(tx_buffer_recover_level));
        cmd(OP_TX_BEGIN, 11'h5a5);
        rd(TX_BEGIN_OFS, 16'h05a5);
        cmd(OP_RX_EARLY, 11'h123);
        chk("rx_early", 64'h123, 64'(rx_early_level));
        cmd(OP_RX_MATCH, 11'h015);
        chk("rx_match", 64'h15, 64'(rx_address_match_reg));
        cmd(OP_WINDOW, 11'h005);
        chk("window", 64'h5, 64'(window_sel));
        wr(CMD_HI_OFS, {8'h00, OP_WINDOW, 3'h0});
        chk("window", 64'h5, 64'(window_sel));
        cmd(OP_IRQ_MASK, 11'h7ff);
        chk("irq_mask", 64'h7f6, 64'(irq_mask_reg));
        cmd(OP_IND_MASK, 11'h0f0);
        chk("ind_mask", 64'h0f0, 64'(indication_mask_reg));
        $display("test loads done");
    endtask

    task automatic t_hash_irq();
        cmd(OP_HASH_BIT, 11'h7e5);
        chk("hash", 64'h1 << 37, hash_filter);
        cmd(OP_HASH_BIT, 11'h025);
        chk("hash", 64'h0, hash_filter);
        @(posedge core_clk);
        irq_event <= 11'h003;
        @(posedge core_clk);
        irq_event <= 11'h000;
        cmd(OP_IRQ_FORCE, 11'h7ff);
        chk("irq_state", 64'h043, 64'(irq_state_reg));
        // An event landing with the clear must survive it
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= CMD_PORT_OFS;
        reg_wdata <= {OP_IRQ_CLEAR, 11'h7ff};
        irq_event <= 11'h001;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        irq_event <= 11'h000;
        #1;
        rd(CMD_PORT_OFS, 16'h0003);
        $display("test hash_irq done");
    endtask

    task automatic t_pulses_stall();
        cmd(OP_PKT_DONE, 11'h7ff);
        chk("done pulse", 64'h1, 64'(packet_complete_pulse));
        @(posedge core_clk);
        #1;
        chk("done pulse", 64'h0, 64'(packet_complete_pulse));
        cmd(OP_DROP_HEAD, 11'h000);
        chk("drop pulse", 64'h1, 64'(drop_head_pulse));
        cmd(OP_SPLIT, 11'h7ff);
        chk("split", 64'h1, 64'(tx_buffer_split));
        cmd(OP_STALL, {7'h7e, UP_HALT});
        chk("up halt", 64'h1, 64'(upload_halted));
        busy_len(HALT_CYC);
        cmd(OP_STALL, {7'h7e, DN_HALT});
        chk("dn halt", 64'h1, 64'(download_halted));
        busy_len(HALT_CYC);
        cmd(OP_STALL, {7'h7e, UP_RESUME});
        cmd(OP_STALL, {7'h00, DN_RESUME});
        rd(CTRL_OFS, 16'h02c0);
        $display("test pulses_stall done");
    endtask

    task automatic t_unused();
        logic [4:0] codes[7] = '{5'h12, 5'h14, 5'h1a, 5'h1c, 5'h1d,
            5'h1e, 5'h1f};
        foreach (codes[i]) begin
            cmd(codes[i], 11'h7ff);
            chk("busy", 64'h0, 64'(operation_busy_flag));
        end
        rd(CTRL_OFS, 16'h02c0);
        rd(CMD_PORT_OFS, 16'h0003);
        rd(TX_BEGIN_OFS, 16'h05a5);
        $display("test unused done");
    endtask

    task automatic t_resets();
        cmd(OP_STALL, {7'h00, DN_HALT});
        busy_len(HALT_CYC);
        cmd(OP_WHOLE_RESET, 11'h6df);
        chk("whole", 64'h1, 64'(reset_req.whole));
        chk("keep", 64'h09f, 64'(reset_req.keep_mask));
        // A command while busy must be dropped
        cmd(OP_TX_ON, 11'h000);
        chk("transmit_on", 64'h0, 64'(transmit_on));
        busy_len(WCYC - 2);
        chk("irq_mask", 64'h0, 64'(irq_mask_reg));
        chk("dn halt", 64'h0, 64'(download_halted));
        cmd(OP_RX_ON, 11'h000);
        cmd(OP_RX_EARLY, 11'h123);
        cmd(OP_RX_RESET, 11'h000);
        chk("rx reset", 64'h1, 64'(reset_req.rx_path));
        busy_len(PATH_RESET_CYC);
        chk("receive_on", 64'h0, 64'(receive_on));
        chk("rx_early", 64'h7ff, 64'(rx_early_level));
        cmd(OP_TX_RESET, 11'h7ff);
        chk("tx reset", 64'h1, 64'(reset_req.tx_path));
        chk("keep", 64'h10f, 64'(reset_req.keep_mask));
        busy_len(PATH_RESET_CYC);
        $display("test resets done");
    endtask

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        irq_event = 11'h000;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_reset_state();
        t_enables();
        t_loads();
        t_hash_irq();
        t_pulses_stall();
        t_unused();
        t_resets();
        end_of_test();
    end
endmodule // nic_command_decoder_bench
`default_nettype wire
